/* File: core/dsio_pkg.sv */
// Constants, types and shared decode helpers of the data space decoder.
// Assumes one core clock domain; every file but the peripheral model imports this package whole.
package dsio_pkg;

   // ----------------------------------------
   // Data space layout
   // ----------------------------------------
   localparam int          RF_SIZE     = 32;
   localparam int          STDIO_SIZE  = 64;
   localparam int          EXTIO_SIZE  = 160;
   localparam int          SRAM_SIZE   = 512;
   localparam logic [15:0] STDIO_BASE  = 16'h0020;
   localparam logic [15:0] EXTIO_BASE  = 16'h0060;
   localparam logic [15:0] SRAM_BASE   = 16'h0100;
   localparam logic [15:0] DATA_END    = 16'h0300;
   localparam logic [7:0]  IO_DATA_OFS = 8'h20;
   localparam logic [5:0]  BIT_IO_LAST = 6'h1F;

   // ----------------------------------------
   // Local registers (I/O addresses) and reset values
   // ----------------------------------------
   localparam int         SCR_COUNT          = 3;
   localparam logic [5:0] SCR_IO [SCR_COUNT] = '{6'h1E, 6'h0A, 6'h0B};
   localparam logic [5:0] FLAG_IO            = 6'h1C;
   localparam logic [7:0] SCR_RST            = 8'h00;
   localparam logic [7:0] FLAG_RST           = 8'h00;
   localparam logic [7:0] RF_RST             = 8'h00;

   // ----------------------------------------
   // Pointer pairs and timing
   // ----------------------------------------
   localparam logic [4:0] PTR_X_LO    = 5'h1A;
   localparam logic [4:0] PTR_Y_LO    = 5'h1C;
   localparam logic [4:0] PTR_Z_LO    = 5'h1E;
   localparam int         SRAM_CYCLES = 2;

   typedef enum logic [2:0] {
      OP_LOAD  = 3'b000, OP_STORE = 3'b001, OP_IN    = 3'b010, OP_OUT   = 3'b011,
      OP_SETB  = 3'b100, OP_CLRB  = 3'b101, OP_SKIP1 = 3'b110, OP_SKIP0 = 3'b111
   } dsio_op_t;

   typedef enum logic [2:0] {
      MD_DIRECT = 3'b000, MD_IND = 3'b001, MD_DISP = 3'b010,
      MD_PREDEC = 3'b011, MD_POSTINC = 3'b100
   } dsio_mode_t;

   typedef enum logic [1:0] {PTR_X = 2'b00, PTR_Y = 2'b01, PTR_Z = 2'b10} dsio_ptr_t;

   typedef enum logic [2:0] {
      RG_RF = 3'b000, RG_STDIO = 3'b001, RG_EXTIO = 3'b010, RG_SRAM = 3'b011, RG_NONE = 3'b100
   } dsio_region_t;

   typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_EXEC = 2'b01, ST_SRAM2 = 2'b10} dsio_state_t;

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic dsio_region_t region_of(input logic [15:0] a);
      if (a < STDIO_BASE)      region_of = RG_RF;
      else if (a < EXTIO_BASE) region_of = RG_STDIO;
      else if (a < SRAM_BASE)  region_of = RG_EXTIO;
      else if (a < DATA_END)   region_of = RG_SRAM;
      else                     region_of = RG_NONE;
   endfunction : region_of

   function automatic logic [15:0] io_data_addr(input logic [5:0] io);
      io_data_addr = {8'h00, IO_DATA_OFS + {2'b00, io}};
   endfunction : io_data_addr

   function automatic logic is_io_op(input dsio_op_t op);
      is_io_op = (op != OP_LOAD) && (op != OP_STORE);
   endfunction : is_io_op

   function automatic logic is_bit_op(input dsio_op_t op);
      is_bit_op = op[2];
   endfunction : is_bit_op

   function automatic logic is_wr_op(input dsio_op_t op);
      is_wr_op = (op == OP_STORE) || (op == OP_OUT) || (op == OP_SETB) || (op == OP_CLRB);
   endfunction : is_wr_op

endpackage : dsio_pkg

/* File: core/dsio_agen_if.sv */
// Address generation request and answer between decoder and generator.
// Assumes purely combinational use within one clock domain.
`timescale 1ns/1ps
interface dsio_agen_if;
   import dsio_pkg::*;
   dsio_mode_t  mode;
   logic [15:0] ptr_val;
   logic [15:0] dir_addr;
   logic [5:0]  disp;
   logic [15:0] eff_addr;
   logic [15:0] ptr_new;
   logic        ptr_wr;

   modport ctrl (output mode, ptr_val, dir_addr, disp, input eff_addr, ptr_new, ptr_wr);
   modport gen  (input mode, ptr_val, dir_addr, disp, output eff_addr, ptr_new, ptr_wr);
endinterface : dsio_agen_if

/* File: core/dsio_addr_gen.sv */
// Effective address and pointer update for the five addressing modes.
// Assumes the caller supplies the selected pointer pair value.
`timescale 1ns/1ps
module dsio_addr_gen
   import dsio_pkg::*;
(
   // Request and answer
   dsio_agen_if.gen a
);

   always_comb begin
      a.eff_addr = a.dir_addr;
      a.ptr_new  = a.ptr_val;
      a.ptr_wr   = 1'b0;
      case (a.mode)
         MD_DIRECT: begin
            a.eff_addr = a.dir_addr;
         end
         MD_IND: begin
            a.eff_addr = a.ptr_val;
         end
         MD_DISP: begin
            a.eff_addr = a.ptr_val + {10'h000, a.disp};
         end
         MD_PREDEC: begin
            a.ptr_new  = a.ptr_val - 16'h0001;
            a.eff_addr = a.ptr_val - 16'h0001;
            a.ptr_wr   = 1'b1;
         end
         MD_POSTINC: begin
            a.eff_addr = a.ptr_val;
            a.ptr_new  = a.ptr_val + 16'h0001;
            a.ptr_wr   = 1'b1;
         end
         default: begin
            a.eff_addr = a.dir_addr;
         end
      endcase
   end

endmodule : dsio_addr_gen

/* File: core/dsio_decoder.sv */
// Data space decoder: register file, I/O, extended I/O, data SRAM, local registers.
// Assumes the core issues one request at a time and peripherals answer reads
// combinationally in the strobe cycle.
`timescale 1ns/1ps
module dsio_decoder
   import dsio_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // Core data access request
   input  wire logic        req_valid_in,
   input  wire dsio_op_t    req_op_in,
   input  wire dsio_mode_t  req_mode_in,
   input  wire dsio_ptr_t   req_ptr_in,
   input  wire logic [15:0] req_addr_in,
   input  wire logic [5:0]  req_io_addr_in,
   input  wire logic [5:0]  req_disp_in,
   input  wire logic [2:0]  req_bit_in,
   input  wire logic [7:0]  req_wdata_in,
   // Core data access answer
   output logic             ready_out,
   output logic             done_out,
   output logic             refused_out,
   output logic             skip_out,
   output logic [7:0]       rd_data_out,
   // Core register file port
   input  wire logic [4:0]  rf_rd_idx_in,
   output logic [7:0]       rf_rd_data_out,
   input  wire logic        rf_wr_en_in,
   input  wire logic [4:0]  rf_wr_idx_in,
   input  wire logic [7:0]  rf_wr_data_in,
   // Peripheral register port
   output logic             io_stb_out,
   output logic             io_we_out,
   output logic [7:0]       io_addr_out,
   output logic [7:0]       io_wdata_out,
   output logic [7:0]       io_mask_out,
   input  wire logic [7:0]  io_rdata_in,
   // Status flag events
   input  wire logic [7:0]  flag_set_in
);

   // ----------------------------------------
   // Storage and request state
   // ----------------------------------------
   logic [7:0]   rf_q [RF_SIZE];
   logic [7:0]   sram_q [SRAM_SIZE];
   logic [7:0]   scr_q [SCR_COUNT];
   logic [7:0]   flags_q;
   dsio_state_t  state_q;
   dsio_op_t     op_q;
   dsio_region_t region_q;
   logic [15:0]  addr_q;
   logic [7:0]   wdata_q;
   logic [7:0]   mask_q;
   logic [2:0]   bit_q;
   logic         refuse_q;
   logic [4:0]   ptr_lo_q;
   logic         done_q;
   logic         refused_q;
   logic         skip_q;
   logic [7:0]   rd_data_q;

   logic         accept;
   logic [4:0]   ptr_lo;
   logic [15:0]  acc_addr;
   logic         acc_refuse;
   logic         exec;
   logic         do_wr;
   logic         do_rd;
   logic [15:0]  sram_off;
   logic [SCR_COUNT-1:0] hit_scr;
   logic         hit_flag;
   logic         own_hit;
   logic [7:0]   flag_clr;
   logic [7:0]   rd_mux;

   dsio_agen_if agen ();

   dsio_addr_gen u_agen (
      .a (agen.gen)
   );

   function automatic logic [4:0] ptr_lo_of(input dsio_ptr_t p);
      case (p)
         PTR_X:   ptr_lo_of = PTR_X_LO;
         PTR_Y:   ptr_lo_of = PTR_Y_LO;
         default: ptr_lo_of = PTR_Z_LO;
      endcase
   endfunction : ptr_lo_of

   // ----------------------------------------
   // Request acceptance and address forming
   // ----------------------------------------
   assign ready_out      = (state_q == ST_IDLE);
   assign accept         = req_valid_in && ready_out;
   assign ptr_lo         = ptr_lo_of(req_ptr_in);
   assign agen.mode      = req_mode_in;
   assign agen.ptr_val   = {rf_q[ptr_lo | 5'h01], rf_q[ptr_lo]};
   assign agen.dir_addr  = req_addr_in;
   assign agen.disp      = req_disp_in;
   // Short I/O ops carry only six address bits, so extended I/O is out of reach
   assign acc_addr   = is_io_op(req_op_in) ? io_data_addr(req_io_addr_in) : agen.eff_addr;
   assign acc_refuse = is_bit_op(req_op_in) && (req_io_addr_in > BIT_IO_LAST);

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (accept) begin
                  state_q <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               // Data SRAM needs a second cycle
               state_q <= (region_q == RG_SRAM && !refuse_q) ? ST_SRAM2 : ST_IDLE;
            end
            ST_SRAM2: begin
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         op_q     <= OP_LOAD;
         region_q <= RG_RF;
         addr_q   <= 16'h0000;
         wdata_q  <= 8'h00;
         mask_q   <= 8'hFF;
         bit_q    <= 3'h0;
         refuse_q <= 1'b0;
         ptr_lo_q <= PTR_X_LO;
      end else if (accept) begin
         op_q     <= req_op_in;
         region_q <= region_of(acc_addr);
         addr_q   <= acc_addr;
         bit_q    <= req_bit_in;
         refuse_q <= acc_refuse;
         ptr_lo_q <= ptr_lo;
         // Bit ops write only the addressed bit through a one-hot mask
         mask_q   <= is_bit_op(req_op_in) ? (8'h01 << req_bit_in) : 8'hFF;
         case (req_op_in)
            OP_SETB: wdata_q <= 8'h01 << req_bit_in;
            OP_CLRB: wdata_q <= 8'h00;
            default: wdata_q <= req_wdata_in;
         endcase
      end
   end

   // ----------------------------------------
   // Execution decode
   // ----------------------------------------
   assign exec     = (state_q == ST_EXEC);
   assign do_wr    = exec && !refuse_q && is_wr_op(op_q);
   assign do_rd    = exec && !refuse_q && !is_wr_op(op_q);
   assign sram_off = addr_q - SRAM_BASE;
   assign hit_flag = (addr_q == io_data_addr(FLAG_IO));
   assign own_hit  = (|hit_scr) || hit_flag;

   genvar g;
   generate
      for (g = 0; g < SCR_COUNT; g++) begin : g_scr
         assign hit_scr[g] = (addr_q == io_data_addr(SCR_IO[g]));

         always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
               scr_q[g] <= SCR_RST;
            end else if (do_wr && hit_scr[g]) begin
               scr_q[g] <= (scr_q[g] & ~mask_q) | (wdata_q & mask_q);
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // Write-one-to-clear status flags
   // ----------------------------------------
   // Writing zero clears nothing; a same-cycle event beats the clear
   assign flag_clr = (do_wr && hit_flag) ? (wdata_q & mask_q) : 8'h00;

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         flags_q <= FLAG_RST;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set_in;
      end
   end

   // ----------------------------------------
   // Working registers
   // ----------------------------------------
   // Pointer update lands at acceptance, the data access a cycle later
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < RF_SIZE; i++) begin
            rf_q[i] <= RF_RST;
         end
      end else begin
         if (rf_wr_en_in) begin
            rf_q[rf_wr_idx_in] <= rf_wr_data_in;
         end
         if (do_wr && region_q == RG_RF) begin
            rf_q[addr_q[4:0]] <= wdata_q;
         end
         if (accept && !is_io_op(req_op_in) && agen.ptr_wr) begin
            rf_q[ptr_lo]         <= agen.ptr_new[7:0];
            rf_q[ptr_lo | 5'h01] <= agen.ptr_new[15:8];
         end
      end
   end

   assign rf_rd_data_out = rf_q[rf_rd_idx_in];

   // ----------------------------------------
   // Data SRAM
   // ----------------------------------------
   always_ff @(posedge clk_in) begin
      if (do_wr && region_q == RG_SRAM) begin
         sram_q[sram_off[8:0]] <= wdata_q;
      end
   end

   // ----------------------------------------
   // Peripheral port and read path
   // ----------------------------------------
   // Unclaimed I/O addresses go out; reserved ones simply read what the peripheral drives
   assign io_stb_out   = exec && !refuse_q && !own_hit &&
                         (region_q == RG_STDIO || region_q == RG_EXTIO);
   assign io_we_out    = io_stb_out && is_wr_op(op_q);
   assign io_addr_out  = addr_q[7:0];
   assign io_wdata_out = wdata_q;
   assign io_mask_out  = mask_q;

   always_comb begin
      rd_mux = 8'h00;
      case (region_q)
         RG_RF: begin
            rd_mux = rf_q[addr_q[4:0]];
         end
         RG_STDIO, RG_EXTIO: begin
            rd_mux = io_rdata_in;
            if (hit_flag) begin
               rd_mux = flags_q;
            end
            for (int i = 0; i < SCR_COUNT; i++) begin
               if (hit_scr[i]) begin
                  rd_mux = scr_q[i];
               end
            end
         end
         RG_SRAM: begin
            rd_mux = sram_q[sram_off[8:0]];
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rd_data_q <= 8'h00;
         skip_q    <= 1'b0;
      end else if (exec) begin
         rd_data_q <= do_rd ? rd_mux : 8'h00;
         skip_q    <= do_rd && (op_q == OP_SKIP1 || op_q == OP_SKIP0) &&
                      (rd_mux[bit_q] == (op_q == OP_SKIP1));
      end
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         done_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         done_q    <= (exec && (refuse_q || region_q != RG_SRAM)) || (state_q == ST_SRAM2);
         refused_q <= exec && refuse_q;
      end
   end

   assign done_out    = done_q;
   assign refused_out = refused_q;
   assign skip_out    = skip_q;
   assign rd_data_out = rd_data_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   sram_two_cycle_a: assert property (
      accept && !acc_refuse && region_of(acc_addr) == RG_SRAM |-> ##1 !done_out ##1 !done_out ##1 done_out
   ) else $error("SRAM access not done after two access cycles");

   io_alias_a: assert property (
      accept && (req_op_in == OP_IN || req_op_in == OP_OUT) |=>
         addr_q == $past({10'h000, req_io_addr_in}) + 16'h0020
   ) else $error("I/O address not offset by 0x20");

   io_no_ext_a: assert property (
      exec && is_io_op(op_q) |-> region_q == RG_STDIO && !(addr_q >= 16'h0060)
   ) else $error("Short I/O op reached extended I/O");

   bit_range_a: assert property (
      accept && is_bit_op(req_op_in) && req_io_addr_in > 6'h1F |-> ##2 refused_out && !skip_out && done_out
   ) else $error("Bit op above 0x1F not refused");

   bit_mask_a: assert property (
      io_we_out && is_bit_op(op_q) |-> $onehot(io_mask_out) && io_mask_out == (8'h01 << bit_q)
   ) else $error("Bit op mask not single bit");

   w1c_keep_a: assert property (
      do_wr && hit_flag |=>
         ((flags_q ^ $past(flags_q)) & ~$past(wdata_q & mask_q) & ~$past(flag_set_in)) == 8'h00
   ) else $error("Flag changed without one written");

   scratch_write_a: assert property (
      do_wr && hit_scr[0] && mask_q == 8'hFF |=> scr_q[0] == $past(wdata_q)
   ) else $error("Scratch register write lost");

   disp_addr_a: assert property (
      accept && req_op_in == OP_LOAD && req_mode_in == MD_DISP |=>
         addr_q == $past(agen.ptr_val) + $past({10'h000, req_disp_in})
   ) else $error("Displacement address wrong");

   post_inc_a: assert property (
      accept && !is_io_op(req_op_in) && req_mode_in == MD_POSTINC && !rf_wr_en_in |=>
         addr_q == $past(agen.ptr_val) &&
         {rf_q[ptr_lo_q | 5'h01], rf_q[ptr_lo_q]} == $past(agen.ptr_val) + 16'h0001
   ) else $error("Post-increment pointer wrong");

   rf_map_a: assert property (
      exec && op_q == OP_LOAD && region_q == RG_RF |=> done_out && rd_data_out == $past(rf_q[addr_q[4:0]])
   ) else $error("Register file read through data space wrong");

   beyond_zero_a: assert property (
      done_out && region_q == RG_NONE |-> rd_data_out == 8'h00 && !io_stb_out
   ) else $error("Access beyond SRAM returned data");

endmodule : dsio_decoder

/* File: test/dsio_periph_model.sv */
// Peripheral register model behind the decoder's I/O strobe.
// Assumes one strobe at a time, answered in the same cycle.
`timescale 1ns/1ps
module dsio_periph_model (
   // Clock
   input  wire logic       clk_in,
   // Strobe side
   input  wire logic       io_stb_in,
   input  wire logic       io_we_in,
   input  wire logic [7:0] io_addr_in,
   input  wire logic [7:0] io_wdata_in,
   input  wire logic [7:0] io_mask_in,
   output logic [7:0]      io_rdata_out
);
   logic [7:0] mem_q [256];
   logic [7:0] last_q;

   initial begin
      mem_q  = '{default: 8'h00};
      last_q = 8'h00;
   end

   // Only bits under the mask change
   always @(posedge clk_in) begin
      if (io_stb_in && io_we_in) begin
         mem_q[io_addr_in] <= (mem_q[io_addr_in] & ~io_mask_in) | (io_wdata_in & io_mask_in);
      end
      if (io_stb_in) begin
         last_q <= io_rdata_out;
      end
   end

   // Idle bus shows the inverse, so a stale value never matches
   assign io_rdata_out = io_stb_in ? mem_q[io_addr_in] : ~last_q;
endmodule : dsio_periph_model

/* File: test/data_space_io_decoder_tb.sv */
// Self-checking bench of the data space decoder.
// Assumes the peripheral model answers every strobe.
`timescale 1ns/1ps
module data_space_io_decoder_tb;
   import dsio_pkg::*;
   logic        clk_in, rst_n_in, req_valid_in, rf_wr_en_in;
   dsio_op_t    req_op_in;
   dsio_mode_t  req_mode_in;
   dsio_ptr_t   req_ptr_in;
   logic [15:0] req_addr_in, rd;
   logic [5:0]  req_io_addr_in, req_disp_in;
   logic [2:0]  req_bit_in;
   logic [7:0]  req_wdata_in, rd_data_out, rf_rd_data_out, rf_wr_data_in;
   logic [7:0]  io_addr_out, io_wdata_out, io_mask_out, io_rdata_in, flag_set_in;
   logic [4:0]  rf_rd_idx_in, rf_wr_idx_in;
   logic        ready_out, done_out, refused_out, skip_out, io_stb_out, io_we_out;
   int          error_cnt, checked, lat, cyc;

   dsio_decoder u_dut (.clk_in, .rst_n_in, .req_valid_in, .req_op_in, .req_mode_in, .req_ptr_in,
      .req_addr_in, .req_io_addr_in, .req_disp_in, .req_bit_in, .req_wdata_in, .ready_out,
      .done_out, .refused_out, .skip_out, .rd_data_out, .rf_rd_idx_in, .rf_rd_data_out,
      .rf_wr_en_in, .rf_wr_idx_in, .rf_wr_data_in, .io_stb_out, .io_we_out, .io_addr_out,
      .io_wdata_out, .io_mask_out, .io_rdata_in, .flag_set_in);
   dsio_periph_model u_per (.clk_in, .io_stb_in(io_stb_out), .io_we_in(io_we_out),
      .io_addr_in(io_addr_out), .io_wdata_in(io_wdata_out), .io_mask_in(io_mask_out),
      .io_rdata_out(io_rdata_in));

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   // One request, held for one cycle; latency counted to done
   task automatic acc(input dsio_op_t op, input dsio_mode_t md, input dsio_ptr_t p,
      input logic [15:0] a, input logic [5:0] io = 6'h00, input logic [2:0] b = 3'h0,
      input logic [7:0] wd = 8'h00, input logic [5:0] ds = 6'h00);
      @(posedge clk_in);
      #2;
      req_valid_in = 1'b1;
      req_op_in = op;
      req_mode_in = md;
      req_ptr_in = p;
      req_addr_in = a;
      req_io_addr_in = io;
      req_bit_in = b;
      req_wdata_in = wd;
      req_disp_in = ds;
      @(posedge clk_in);
      #2;
      req_valid_in = 1'b0;
      chk({15'h0000, ready_out}, 16'h0000);
      lat = 0;
      while (done_out !== 1'b1 && lat < 8) begin
         @(posedge clk_in);
         #2;
         lat++;
      end
      // A request that never completes counts as a mismatch
      if (done_out !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t request never completed", $time);
      end
      chk({15'h0000, ready_out}, 16'h0001);
      rd = {8'h00, rd_data_out};
   endtask : acc

   task automatic rf_w(input logic [4:0] i, input logic [7:0] v);
      @(posedge clk_in);
      #2;
      rf_wr_en_in = 1'b1;
      rf_wr_idx_in = i;
      rf_wr_data_in = v;
      @(posedge clk_in);
      #2;
      rf_wr_en_in = 1'b0;
   endtask : rf_w

   task automatic pk(input logic [4:0] i, input logic [7:0] v);
      rf_rd_idx_in = i;
      #1;
      chk({8'h00, rf_rd_data_out}, {8'h00, v});
   endtask : pk

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_scratch();
      for (int i = 0; i < SCR_COUNT; i++) begin
         acc(OP_IN, MD_DIRECT, PTR_X, 16'h0000, SCR_IO[i]);
         chk(rd, 16'h0000);
         acc(OP_OUT, MD_DIRECT, PTR_X, 16'h0000, SCR_IO[i], 3'h0, 8'hC0 + 8'(i));
      end
      for (int i = 0; i < SCR_COUNT; i++) begin
         acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h0020 + {10'h000, SCR_IO[i]});
         chk(rd, 16'h00C0 + 16'(i));
      end
      $display("scratch test done");
   endtask : t_scratch

   // Stimulus writes mapped places and the unmapped 0x0300, reserved bits zero
   task automatic t_regions();
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h0005, 6'h00, 3'h0, 8'h77);
      pk(5'h05, 8'h77);
      rf_w(5'h1F, 8'h12);
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h001F);
      chk(rd, 16'h0012);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h0100, 6'h00, 3'h0, 8'h5A);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h02FF, 6'h00, 3'h0, 8'hC3);
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h0100);
      chk(rd, 16'h005A);
      chk(16'(lat), 16'(SRAM_CYCLES));
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h02FF);
      chk(rd, 16'h00C3);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h0060, 6'h00, 3'h0, 8'h3C);
      chk({8'h00, u_per.mem_q[8'h60]}, 16'h003C);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h00FF, 6'h00, 3'h0, 8'h81);
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h00FF);
      chk({rd[7:0], 8'(lat)}, 16'h8101);
      acc(OP_OUT, MD_DIRECT, PTR_X, 16'h0000, 6'h10, 3'h0, 8'hA5);
      chk({8'h00, u_per.mem_q[8'h30]}, 16'h00A5);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h0300, 6'h00, 3'h0, 8'hEE);
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h0300);
      chk({rd[7:0], 8'(lat)}, 16'h0001);
      $display("region test done");
   endtask : t_regions

   task automatic t_bits();
      acc(OP_SETB, MD_DIRECT, PTR_X, 16'h0000, 6'h10, 3'h1);
      acc(OP_CLRB, MD_DIRECT, PTR_X, 16'h0000, 6'h10, 3'h7);
      acc(OP_LOAD, MD_DIRECT, PTR_X, 16'h0030);
      chk(rd, 16'h0027);
      acc(OP_SKIP1, MD_DIRECT, PTR_X, 16'h0000, 6'h10, 3'h0);
      chk({15'h0000, skip_out}, 16'h0001);
      acc(OP_SKIP0, MD_DIRECT, PTR_X, 16'h0000, 6'h10, 3'h0);
      chk({15'h0000, skip_out}, 16'h0000);
      acc(OP_SETB, MD_DIRECT, PTR_X, 16'h0000, 6'h1F, 3'h2);
      chk({u_per.mem_q[8'h3F], 7'h00, refused_out}, 16'h0400);
      for (int k = 4; k < 8; k++) begin
         acc(dsio_op_t'(k[2:0]), MD_DIRECT, PTR_X, 16'h0000, 6'h20, 3'h0);
         chk({15'h0000, refused_out}, 16'h0001);
      end
      chk({8'h00, u_per.mem_q[8'h40]}, 16'h0000);
      $display("bit test done");
   endtask : t_bits

   task automatic t_flags();
      @(posedge clk_in);
      #2;
      flag_set_in = 8'h05;
      @(posedge clk_in);
      #2;
      flag_set_in = 8'h00;
      acc(OP_OUT, MD_DIRECT, PTR_X, 16'h0000, FLAG_IO, 3'h0, 8'h00);
      acc(OP_IN, MD_DIRECT, PTR_X, 16'h0000, FLAG_IO);
      chk(rd, 16'h0005);
      acc(OP_SETB, MD_DIRECT, PTR_X, 16'h0000, FLAG_IO, 3'h0);
      acc(OP_IN, MD_DIRECT, PTR_X, 16'h0000, FLAG_IO);
      chk(rd, 16'h0004);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h003C, 6'h00, 3'h0, 8'h04);
      acc(OP_IN, MD_DIRECT, PTR_X, 16'h0000, FLAG_IO);
      chk(rd, 16'h0000);
      $display("flag test done");
   endtask : t_flags

   task automatic t_ptrs();
      rf_w(PTR_X_LO, 8'h00);
      rf_w(PTR_X_LO + 5'h01, 8'h01);
      acc(OP_STORE, MD_POSTINC, PTR_X, 16'h0000, 6'h00, 3'h0, 8'h11);
      pk(PTR_X_LO, 8'h01);
      acc(OP_LOAD, MD_PREDEC, PTR_X, 16'h0000);
      chk(rd, 16'h0011);
      pk(PTR_X_LO, 8'h00);
      rf_w(PTR_Y_LO, 8'hF0);
      rf_w(PTR_Y_LO + 5'h01, 8'h00);
      acc(OP_STORE, MD_DIRECT, PTR_X, 16'h012F, 6'h00, 3'h0, 8'h99);
      acc(OP_LOAD, MD_DISP, PTR_Y, 16'h0000, 6'h00, 3'h0, 8'h00, 6'h3F);
      chk(rd, 16'h0099);
      rf_w(PTR_Z_LO, 8'h3E);
      rf_w(PTR_Z_LO + 5'h01, 8'h00);
      acc(OP_LOAD, MD_IND, PTR_Z, 16'h0000);
      chk(rd, 16'h00C0);
      $display("pointer test done");
   endtask : t_ptrs

   // ----------------------------------------
   // Clock, run and verdict
   // ----------------------------------------
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // Whole run is under two hundred cycles
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         error_cnt++;
         close_out();
      end
   end

   initial begin
      {rst_n_in, req_valid_in, rf_wr_en_in} = 3'b000;
      req_op_in = OP_LOAD;
      req_mode_in = MD_DIRECT;
      req_ptr_in = PTR_X;
      {req_addr_in, req_io_addr_in, req_disp_in, req_bit_in} = 31'h0;
      {req_wdata_in, rf_wr_data_in, flag_set_in, rf_rd_idx_in, rf_wr_idx_in} = 34'h0;
      repeat (16) @(posedge clk_in);
      #2;
      rst_n_in = 1'b1;
      t_scratch();
      t_regions();
      t_bits();
      t_flags();
      t_ptrs();
      close_out();
   end
endmodule : data_space_io_decoder_tb
